// ### hdl/rdwo_pkg.sv
// Operation
// [RL1] Data addresses 0x40..0x7F read program memory through the window.
// [RL2] Window shows 64 consecutive program bytes anywhere in 0x000..0xFFF.
// [RL3] Program memory splits into 64 aligned blocks of 64 bytes.
// [RL4] Block n covers addresses n*64 through n*64+63.
// [RL5] Block-select bits 5:0 form program address bits 11:6; bits 7:6 reserved.
// [RL6] Data address bits 5:0 give the byte offset inside the block.
// [RL7] Block select at 0xC9, write only, undefined after reset.
// [RL8] Software writes the block select before the first window read.
// [RL9] Software never reads or read-modify-writes the block select.
// [RL10] Interrupt handlers keep a RAM image, written before the register.
// [RL11] Option bytes are unmapped; reachable only in programming mode.
// [RL12] Each option byte programs once and then cannot change.
// [RL13] Factory-coded parts fix options by mask and never read them.
// [RL14] Programmable parts leave the factory with all-zero options.
// [RL15] Bit 9 clear bars stop under watchdog; set allows it with NMI high.
// [RL16] Bit 8 enables the low-voltage detector.
// [RL17] Bit 7 set blocks external readout of program memory.
// [RL18] Bit 6 selects oscillator: zero crystal or clock, one RC.
// [RL19] Bit 3 enables the NMI pin pull-up.
// [RL20] Bit 1 selects hardware watchdog, zero software-enabled.
// [RL21] Bit 0 enables the oscillator safeguard.
// [RL22] Programmer writes reserved bits 15:11,5 clear and 10,4,2 set.
// [RL23] Window read answers within normal read timing using current select.
package rdwo_pkg;
  localparam logic [7:0] WIN_BASE = 8'h40;
  localparam logic [7:0] WIN_LAST = 8'h7f;
  localparam logic [7:0] BLOCK_SEL_ADDR = 8'hc9;
  localparam int BLOCK_BITS = 6;
  localparam int OFFSET_BITS = 6;
  localparam int PADDR_BITS = 12;
  localparam logic [7:0] OTP_BLANK = 8'h00;
  localparam int OPT_STOP_EXT = 9;
  localparam int OPT_LOW_VOLT = 8;
  localparam int OPT_PROTECT = 7;
  localparam int OPT_OSC_RC = 6;
  localparam int OPT_NMI_PULL = 3;
  localparam int OPT_HW_WDG = 1;
  localparam int OPT_OSG = 0;
  localparam logic [15:0] OPT_RSVD_MASK = 16'hf834;
  localparam logic [15:0] OPT_RSVD_VAL = 16'h0414;
endpackage

// ### hdl/rdwo_block_select.sv
`timescale 1ns/1ps
module rdwo_block_select
  import rdwo_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Write strobe and data.
  input wire logic wrSel,
  input wire logic [7:0] wrData,
  // Current block number.
  output logic [BLOCK_BITS-1:0] blockNum
);
  import rdwo_pkg::*;

  typedef struct packed {
    logic [BLOCK_BITS-1:0] blk;
  } rdwo_bs_t;

  rdwo_bs_t state_r;
  rdwo_bs_t state_nxt;

  // Only bits 5:0 are kept; reserved bits are dropped. Reset value is zero,
  // since software must not rely on it anyway.
  always_comb
  begin
    state_nxt = state_r;
    if (wrSel)
    begin
      state_nxt.blk = wrData[BLOCK_BITS-1:0]; // see [RL5] see [RL7]
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign blockNum = state_r.blk;

  selUpdate_a: assert property (@(posedge clock) disable iff (!rstn)
    wrSel |=> blockNum == $past(wrData[BLOCK_BITS-1:0])) // see [RL5]
    else $error("block select did not take the written value");
endmodule

// ### hdl/rdwo_option_store.sv
`timescale 1ns/1ps
module rdwo_option_store
  import rdwo_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Programming port.
  input wire logic progMode,
  input wire logic maskRom,
  input wire logic [15:0] maskValue,
  input wire logic progWrite,
  input wire logic [15:0] progData,
  // Option word and readback.
  output logic [15:0] options,
  output logic [15:0] progReadData
);
  import rdwo_pkg::*;

  typedef struct packed {
    logic [15:0] val;
    logic [1:0] burnt;
    logic [15:0] rd;
  } rdwo_opt_t;

  rdwo_opt_t state_r;
  rdwo_opt_t state_nxt;

  // Each byte burns once in programming mode; masked parts ignore writes.
  // Reset models the blank fuse array as zero; real fuses would keep state.
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.rd = '0;
    if (progMode && !maskRom)
    begin
      state_nxt.rd = state_r.val; // see [RL11]
      if (progWrite && !state_r.burnt[1])
      begin
        state_nxt.val[15:8] = progData[15:8]; // see [RL12]
        state_nxt.burnt[1] = 1'b1;
      end
      if (progWrite && !state_r.burnt[0])
      begin
        state_nxt.val[7:0] = progData[7:0]; // see [RL12]
        state_nxt.burnt[0] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= '{val: {OTP_BLANK, OTP_BLANK}, burnt: 2'b00, rd: 16'h0000}; // see [RL14]
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign options = maskRom ? maskValue : state_r.val; // see [RL13]
  assign progReadData = state_r.rd;

  noMaskRead_a: assert property (@(posedge clock) disable iff (!rstn)
    maskRom |=> progReadData == 16'h0000) // see [RL13]
    else $error("masked options became readable");
  burnOnce_a: assert property (@(posedge clock) disable iff (!rstn)
    (&state_r.burnt) |=> state_r.val == $past(state_r.val)) // see [RL12]
    else $error("burnt option changed");
endmodule

// ### hdl/rdwo_window.sv
`timescale 1ns/1ps
module rdwo_window
  import rdwo_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // CPU data-space bus.
  input wire logic [7:0] dataAddr,
  input wire logic dataRd,
  input wire logic dataWr,
  input wire logic [7:0] dataWrData,
  output logic dataHit,
  output logic [7:0] dataRdData,
  // Program memory port.
  output logic [PADDR_BITS-1:0] progAddr,
  input wire logic [7:0] progRdData,
  // Programming mode and option programming.
  input wire logic progMode,
  input wire logic maskRom,
  input wire logic [15:0] maskValue,
  input wire logic optWrite,
  input wire logic [15:0] optWrData,
  output logic [15:0] optRdData,
  // External readout request.
  input wire logic extRdReq,
  output logic [7:0] extRdData,
  // NMI pin and watchdog state inputs, configuration outputs.
  input wire logic nmiPin,
  input wire logic watchdogActive,
  output logic stopAllowed,
  output logic external_stop_control,
  output logic low_voltage_detector_enable,
  output logic readoutProtect,
  output logic oscRcSelect,
  output logic nmiPullUpEnable,
  output logic hardware_watchdog_select,
  output logic oscillator_safeguard_enable
);
  import rdwo_pkg::*;

  typedef struct packed {
    logic nmiMeta;
    logic nmiSync;
    logic [7:0] rdData;
    logic hit;
    logic [7:0] extData;
  } rdwo_win_t;

  rdwo_win_t state_r;
  rdwo_win_t state_nxt;
  logic [BLOCK_BITS-1:0] blockNum;
  logic [15:0] options;
  logic inWindow;

  //////////////////////////////////////////////////////////////////////////////

  function automatic logic inRange(input logic [7:0] a);
    inRange = (a >= WIN_BASE) && (a <= WIN_LAST);
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  rdwo_block_select u_rdwo_block_select (
    .clock(clock),
    .rstn(rstn),
    .wrSel(dataWr && (dataAddr == BLOCK_SEL_ADDR)), // see [RL7]
    .wrData(dataWrData),
    .blockNum(blockNum)
  );

  rdwo_option_store u_rdwo_option_store (
    .clock(clock),
    .rstn(rstn),
    .progMode(progMode),
    .maskRom(maskRom),
    .maskValue(maskValue),
    .progWrite(optWrite),
    .progData(optWrData),
    .options(options),
    .progReadData(optRdData)
  );

  //////////////////////////////////////////////////////////////////////////////

  // Window decode; the block select is never a read target, so 0xC9 misses.
  assign inWindow = inRange(dataAddr); // see [RL1]

  // External readout in programming mode reuses this same address path.
  // Block number forms the top bits and the data address the offset.
  assign progAddr = {blockNum, dataAddr[OFFSET_BITS-1:0]}; // see [RL2] see [RL3] see [RL4] see [RL6]

  // One-cycle read: data registered at the edge that takes the request.
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.nmiMeta = nmiPin;
    state_nxt.nmiSync = state_r.nmiMeta;
    state_nxt.hit = dataRd && inWindow;
    state_nxt.rdData = (dataRd && inWindow) ? progRdData : 8'h00; // see [RL1] see [RL23]
    state_nxt.extData = 8'h00;
    if (progMode && extRdReq && !options[OPT_PROTECT])
    begin
      state_nxt.extData = progRdData; // see [RL17]
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign dataHit = state_r.hit;
  assign dataRdData = state_r.rdData;
  assign extRdData = state_r.extData;

  // Option bits drive the configuration straight from the store.
  assign external_stop_control = options[OPT_STOP_EXT];
  assign low_voltage_detector_enable = options[OPT_LOW_VOLT]; // see [RL16]
  assign readoutProtect = options[OPT_PROTECT]; // see [RL17]
  assign oscRcSelect = options[OPT_OSC_RC]; // see [RL18]
  assign nmiPullUpEnable = options[OPT_NMI_PULL]; // see [RL19]
  assign hardware_watchdog_select = options[OPT_HW_WDG]; // see [RL20]
  assign oscillator_safeguard_enable = options[OPT_OSG]; // see [RL21]

  // Stop needs an idle watchdog unless external control and a high NMI pin.
  assign stopAllowed = !watchdogActive || (options[OPT_STOP_EXT] && state_r.nmiSync); // see [RL15]

  //////////////////////////////////////////////////////////////////////////////

  sequence winReq_s;
    dataRd && inWindow;
  endsequence

  sequence winAns_s;
    dataHit && (dataRdData == $past(progRdData));
  endsequence

  winRead_a: assert property (@(posedge clock) disable iff (!rstn)
    winReq_s |=> winAns_s) // see [RL23]
    else $error("window read data wrong");
  winDecode_a: assert property (@(posedge clock) disable iff (!rstn)
    dataRd && !inWindow |=> !dataHit && dataRdData == 8'h00) // see [RL1]
    else $error("read outside window hit");
  addrForm_a: assert property (@(posedge clock) disable iff (!rstn)
    progAddr[OFFSET_BITS-1:0] == dataAddr[OFFSET_BITS-1:0]
    && progAddr[PADDR_BITS-1:OFFSET_BITS] == blockNum) // see [RL6]
    else $error("program address malformed");
  protectRead_a: assert property (@(posedge clock) disable iff (!rstn)
    readoutProtect |=> extRdData == 8'h00) // see [RL17]
    else $error("protected memory read out");
  stopGate_a: assert property (@(posedge clock) disable iff (!rstn)
    watchdogActive && !external_stop_control |-> !stopAllowed) // see [RL15]
    else $error("stop allowed under watchdog");
  selWrite_a: assert property (@(posedge clock) disable iff (!rstn)
    dataWr && dataAddr == BLOCK_SEL_ADDR ##1 dataRd && inWindow
    |-> progAddr[PADDR_BITS-1:OFFSET_BITS] == $past(dataWrData[BLOCK_BITS-1:0])) // see [RL5]
    else $error("window ignores new block");
  optMirror_a: assert property (@(posedge clock) disable iff (!rstn)
    maskRom |-> {low_voltage_detector_enable, oscillator_safeguard_enable}
    == {maskValue[OPT_LOW_VOLT], maskValue[OPT_OSG]}) // see [RL13]
    else $error("mask options not applied");
  optRdMap_a: assert property (@(posedge clock) disable iff (!rstn)
    !progMode |=> optRdData == 16'h0000) // see [RL11]
    else $error("options visible outside programming mode");
endmodule

// ### bench/rdwo_prog_mem.sv
`timescale 1ns/1ps
// Program memory stand-in: each byte scrambles its own address, so a wrong block or offset reads wrong.
module rdwo_prog_mem
  import rdwo_pkg::*;
(
  // Read port.
  input wire logic [PADDR_BITS-1:0] addr,
  output logic [7:0] rdData
);
  // Answered in the same cycle, as an asynchronous array read would be.
  assign rdData = addr[7:0] ^ {addr[11:6], addr[11:10]};
endmodule

// ### bench/test_rom_data_window_and_options.sv
`timescale 1ns/1ps
module test_rom_data_window_and_options;
  import rdwo_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] dataAddr = 8'h00;
  logic dataRd = 1'b0;
  logic dataWr = 1'b0;
  logic [7:0] dataWrData = 8'h00;
  logic dataHit;
  logic [7:0] dataRdData;
  logic [PADDR_BITS-1:0] progAddr;
  logic [7:0] progRdData;
  logic progMode = 1'b0;
  logic maskRom = 1'b0;
  logic [15:0] maskValue = 16'h0655;
  logic optWrite = 1'b0;
  logic [15:0] optWrData = 16'h0000;
  logic [15:0] optRdData;
  logic extRdReq = 1'b0;
  logic [7:0] extRdData;
  logic nmiPin = 1'b0;
  logic watchdogActive = 1'b0;
  logic stopAllowed;
  logic [6:0] cfg;
  int failures = 0;
  int totalChecks = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////
  // Design and program memory.
  rdwo_window u_rdwo_window (.clock(clock), .rstn(rstn), .dataAddr(dataAddr), .dataRd(dataRd),
    .dataWr(dataWr), .dataWrData(dataWrData), .dataHit(dataHit), .dataRdData(dataRdData),
    .progAddr(progAddr), .progRdData(progRdData), .progMode(progMode), .maskRom(maskRom),
    .maskValue(maskValue), .optWrite(optWrite), .optWrData(optWrData), .optRdData(optRdData),
    .extRdReq(extRdReq), .extRdData(extRdData), .nmiPin(nmiPin), .watchdogActive(watchdogActive),
    .stopAllowed(stopAllowed), .external_stop_control(cfg[6]), .low_voltage_detector_enable(cfg[5]),
    .readoutProtect(cfg[4]), .oscRcSelect(cfg[3]), .nmiPullUpEnable(cfg[2]),
    .hardware_watchdog_select(cfg[1]), .oscillator_safeguard_enable(cfg[0]));
  rdwo_prog_mem u_rdwo_prog_mem (.addr(progAddr), .rdData(progRdData));

  // Clock, and a cycle ceiling far above the roughly 63 cycles the run needs.
  always #20 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////
  // Shared helpers.
  function automatic logic [7:0] memByte(input logic [11:0] a);
    return a[7:0] ^ {a[11:6], a[11:10]};
  endfunction
  function automatic logic [15:0] cfgOf(input logic [15:0] w);
    return {9'h000, w[9], w[8], w[7], w[6], w[3], w[1], w[0]};
  endfunction
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d, failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic do_reset;
    rstn <= 1'b0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
  endtask
  // One bus cycle; strobes stay up until the next call replaces them.
  task automatic op(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    dataWr <= wr;
    dataRd <= rd;
    dataAddr <= a;
    dataWrData <= d;
  endtask
  task automatic rd(input logic [7:0] a, input logic hit, input logic [7:0] d);
    op(1'b0, 1'b1, a, 8'h00);
    op(1'b0, 1'b0, a, 8'h00);
    #1;
    chk("window hit", {15'h0000, dataHit}, {15'h0000, hit});
    chk("window data", {8'h00, dataRdData}, {8'h00, d});
  endtask
  task automatic ext_read(input logic [7:0] exp);
    @(posedge clock);
    dataAddr <= 8'h45;
    extRdReq <= 1'b1;
    @(posedge clock);
    extRdReq <= 1'b0;
    #1;
    chk("readout", {8'h00, extRdData}, {8'h00, exp});
  endtask
  task automatic burn(input logic [15:0] v);
    @(posedge clock);
    optWrite <= 1'b1;
    optWrData <= v;
    @(posedge clock);
    optWrite <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  ////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic test_window;
    logic [5:0] blk [3] = '{6'h00, 6'h01, 6'h3f};
    foreach (blk[i])
    begin
      // The RAM image goes first, so an interrupt between the two writes loses nothing.
      op(1'b1, 1'b0, 8'h20, {2'h0, blk[i]});
      op(1'b1, 1'b0, BLOCK_SEL_ADDR, {2'h0, blk[i]});
      rd(WIN_BASE, 1'b1, memByte({blk[i], 6'h00}));
      rd(WIN_LAST, 1'b1, memByte({blk[i], 6'h3f}));
    end
  endtask
  // The block select itself is never read back, only its neighbour 0xC8 and the window's neighbours 0x3F and 0x80.
  task automatic test_refused;
    rd(8'h3f, 1'b0, 8'h00);
    rd(8'h80, 1'b0, 8'h00);
    rd(8'hc8, 1'b0, 8'h00);
    op(1'b1, 1'b0, 8'hc8, 8'h07);
    rd(8'h4a, 1'b1, memByte(12'hfca));
  endtask
  // Blank part: readout open, then burn every option on and confirm a second burn is ignored.
  task automatic test_otp;
    @(posedge clock);
    watchdogActive <= 1'b1;
    nmiPin <= 1'b1;
    progMode <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk("blank options", {9'h000, cfg}, 16'h0000);
    chk("stop blank", {15'h0000, stopAllowed}, 16'h0000);
    ext_read(memByte(12'hfc5));
    burn(16'h07df);
    chk("option read", optRdData, 16'h07df);
    chk("config", {9'h000, cfg}, cfgOf(16'h07df));
    chk("stop nmi high", {15'h0000, stopAllowed}, 16'h0001);
    burn(16'h0414);
    chk("reburn", optRdData, 16'h07df);
    ext_read(8'h00);
    @(posedge clock);
    nmiPin <= 1'b0;
    progMode <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk("stop nmi low", {15'h0000, stopAllowed}, 16'h0000);
    chk("option hidden", optRdData, 16'h0000);
    @(posedge clock);
    watchdogActive <= 1'b0;
    #1;
    chk("stop idle watchdog", {15'h0000, stopAllowed}, 16'h0001);
  endtask
  // Factory-coded part: options come from the mask and never read back.
  task automatic test_mask;
    @(posedge clock);
    maskRom <= 1'b1;
    do_reset();
    progMode <= 1'b1;
    burn(16'h07df);
    chk("mask config", {9'h000, cfg}, cfgOf(16'h0655));
    chk("mask read", optRdData, 16'h0000);
  endtask

  initial
  begin
    do_reset();
    test_window();
    test_refused();
    test_otp();
    test_mask();
    test_done();
  end
endmodule
